// ==== hw/sdces_top.sv ====
// Card event status register bank with APB slave and data path tracking
`timescale 1ns/1ps
// Summary of operation
// - Bit 12 sets when a programmed-length transfer finishes; zero otherwise.
// - Bit 11 sets on a selected DAT3 edge; a status read clears it.
// - Bit 10 sets when a new word lands in the receive register.
// - Receive ready clears on data reset, data-clear command or receive read.
// - Transmit ready bit 9 sets on data reset, data-clear command or write.
// - Transmit ready low means register sent and free for new data.
// - Bit 7 sets on a response CRC mismatch.
// - Bit 6 sets on a read-data block CRC mismatch.
// - Bit 5 sets on a write-data CRC error reported by the card.
// - Bit 4 sets when the response time-out expires.
// - Bit 3 sets when the read-data time-out expires.
// - Bit 2 sets on good response or fully sent no-response command.
// - Bit 1 sets on busy release or when expected busy is absent.
// - Bit 0 sets at transfer end after CRC check and programming complete.
// - Transfer done sets on the last byte, possibly before data done.
// - Commands are accepted at any time, even during a block transfer.
// - Command during transfer holds data path only if it expects busy.
// - Status read clears event bits except receive and transmit ready.
// - A masked 0-to-1 status transition raises the interrupt.
// - Data reset control holds the data-line logic in reset.
module sdces_top
    import sdces_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Command path events
    input wire logic cmd_issue,
    input wire logic cmd_data_clear,
    input wire logic cmd_busy_expected,
    input wire logic resp_done,
    input wire logic resp_crc_err,
    input wire logic resp_timeout_evt,
    // Data path events
    input wire logic xfer_start,
    input wire logic last_byte_done,
    input wire logic read_crc_err,
    input wire logic write_crc_err,
    input wire logic read_timeout_evt,
    input wire logic crc_check_done,
    input wire logic card_prog_done,
    input wire logic busy_released,
    input wire logic busy_not_seen,
    // Receive and transmit words
    input wire logic rx_word_valid,
    input wire logic [31:0] rx_word,
    input wire logic dma_rx_read,
    input wire logic dma_tx_write,
    input wire logic [31:0] dma_tx_word,
    input wire logic tx_word_taken,
    output logic [31:0] tx_word,
    // Card pin
    input wire logic dat3_in,
    // To data path and processor
    output logic data_path_reset,
    output logic data_path_hold,
    output logic irq
);
    logic [12:0] status_r;
    logic [12:0] status_nxt;
    logic [12:0] mask_r;
    logic [12:0] mask_nxt;
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic [31:0] rxd_r;
    logic [31:0] rxd_nxt;
    logic [31:0] txd_r;
    logic [31:0] txd_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pready_r;
    logic pready_nxt;
    logic pslverr_r;
    logic pslverr_nxt;
    logic irq_r;
    logic irq_nxt;
    logic hold_r;
    logic hold_nxt;
    logic crc_seen_r;
    logic crc_seen_nxt;
    logic prog_seen_r;
    logic prog_seen_nxt;
    sdces_dp_e dp_r;
    sdces_dp_e dp_nxt;
    logic [12:0] rd_clear;
    logic [12:0] set_ev;
    logic access;
    logic first;
    logic dreset;
    logic data_clear_flag;
    logic rx_read;
    logic tx_write;
    logic dat3_edge;

    // Decoded register hit; unknown addresses answer with an error
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == ADDR_STATUS) || (a == ADDR_CTRL) ||
            (a == ADDR_MASK) || (a == ADDR_RXDATA) || (a == ADDR_TXDATA);
    endfunction : mapped

    sdces_dat3_edge u_dat3 (
        .pclk(pclk),
        .presetn(presetn),
        .hold_reset(ctrl_r[C_DATA_RESET]),
        .edge_sel(ctrl_r[C_EDGE_HI:C_EDGE_LO]),
        .dat3_in(dat3_in),
        .edge_pulse(dat3_edge)
    );

    // APB: one wait state; read data is captured in the first access cycle
    always_comb begin
        first = psel & penable & ~pready_r;
        access = psel & penable & pready_r;
        pready_nxt = first;
        pslverr_nxt = first & ~mapped(paddr);
        prdata_nxt = prdata_r;
        if (first) begin
            prdata_nxt = 32'h0000_0000;
            if (!pwrite) begin
                case (paddr)
                    ADDR_STATUS: prdata_nxt = {19'h0_0000, status_r};
                    ADDR_CTRL: prdata_nxt = {24'h00_0000, ctrl_r};
                    ADDR_MASK: prdata_nxt = {19'h0_0000, mask_r};
                    ADDR_RXDATA: prdata_nxt = rxd_r;
                    ADDR_TXDATA: prdata_nxt = txd_r;
                    default: prdata_nxt = 32'h0000_0000;
                endcase
            end
        end
    end

    // Register writes take effect only on the completing edge
    always_comb begin
        ctrl_nxt = ctrl_r;
        mask_nxt = mask_r;
        txd_nxt = txd_r;
        tx_write = dma_tx_write;
        if (dma_tx_write) begin
            txd_nxt = dma_tx_word;
        end
        if (access && pwrite) begin
            case (paddr)
                ADDR_CTRL: ctrl_nxt = pwdata[7:0];
                ADDR_MASK: mask_nxt = pwdata[12:0] & READ_CLEAR_MASK
                    | pwdata[12:0] & ~READ_CLEAR_MASK;
                ADDR_TXDATA: begin
                    txd_nxt = pwdata;
                    tx_write = 1'b1;
                end
                default: ctrl_nxt = ctrl_r;
            endcase
        end
        // Unused control bits read back as zero
        ctrl_nxt[5:1] = 5'h00;
    end

    // Receive register capture
    always_comb begin
        rxd_nxt = rxd_r;
        if (rx_word_valid) begin
            rxd_nxt = rx_word;
        end
        rx_read = dma_rx_read | (access & ~pwrite & (paddr == ADDR_RXDATA));
    end

    // Data path tracking for commands issued mid-transfer
    always_comb begin
        dp_nxt = dp_r;
        hold_nxt = 1'b0;
        case (dp_r)
            DP_IDLE: begin
                if (xfer_start) begin
                    dp_nxt = DP_XFER;
                end
            end
            DP_XFER: begin
                if (cmd_issue && cmd_busy_expected) begin
                    dp_nxt = DP_WAIT_BUSY;
                    hold_nxt = 1'b1;
                end else if (last_byte_done) begin
                    dp_nxt = DP_IDLE;
                end
            end
            DP_WAIT_BUSY: begin
                hold_nxt = 1'b1;
                if (busy_released || busy_not_seen) begin
                    dp_nxt = DP_IDLE;
                    hold_nxt = 1'b0;
                end
            end
            default: dp_nxt = DP_IDLE;
        endcase
        if (dreset) begin
            dp_nxt = DP_IDLE;
            hold_nxt = 1'b0;
        end
    end

    // Status events
    always_comb begin
        dreset = ctrl_r[C_DATA_RESET];
        // Commands are never gated by the data path state
        data_clear_flag = cmd_issue & cmd_data_clear;
        crc_seen_nxt = crc_seen_r | crc_check_done;
        prog_seen_nxt = prog_seen_r | card_prog_done;
        if (last_byte_done) begin
            crc_seen_nxt = crc_check_done;
            prog_seen_nxt = card_prog_done;
        end
        set_ev = 13'h0000;
        set_ev[B_XFER_DONE] = last_byte_done;
        set_ev[B_DAT3_EDGE] = dat3_edge;
        set_ev[B_RESP_CRC] = resp_crc_err;
        set_ev[B_READ_CRC] = read_crc_err;
        set_ev[B_WRITE_CRC] = write_crc_err;
        set_ev[B_RESP_TIMEOUT] = resp_timeout_evt;
        set_ev[B_READ_TIMEOUT] = read_timeout_evt;
        set_ev[B_CMD_RESP_DONE] = resp_done;
        set_ev[B_BUSY_DONE] = busy_released | busy_not_seen;
        // Data done waits for both CRC check and card programming
        set_ev[B_DATA_COMPLETE] = crc_seen_nxt & prog_seen_nxt &
            (crc_check_done | card_prog_done | last_byte_done);
        if (set_ev[B_DATA_COMPLETE]) begin
            crc_seen_nxt = 1'b0;
            prog_seen_nxt = 1'b0;
        end
        // Clear only what the read actually returned
        rd_clear = 13'h0000;
        if (access && !pwrite && paddr == ADDR_STATUS) begin
            rd_clear = prdata_r[12:0] & READ_CLEAR_MASK;
        end
        status_nxt = (status_r & ~rd_clear) |
            (set_ev & READ_CLEAR_MASK);
        if (rx_word_valid) begin
            status_nxt[B_RX_READY] = 1'b1;
        end else if (rx_read || data_clear_flag) begin
            status_nxt[B_RX_READY] = 1'b0;
        end
        if (tx_write || data_clear_flag || tx_word_taken == 1'b0 && dreset) begin
            status_nxt[B_TX_READY] = 1'b1;
        end else if (tx_word_taken) begin
            status_nxt[B_TX_READY] = 1'b0;
        end
        if (dreset) begin
            status_nxt[B_RX_READY] = 1'b0;
            status_nxt[B_TX_READY] = 1'b1;
            crc_seen_nxt = 1'b0;
            prog_seen_nxt = 1'b0;
        end
        status_nxt[8] = 1'b0;
        // Pulse on any newly set bit whose enable is on
        irq_nxt = |(status_nxt & ~status_r & mask_r);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r <= STATUS_RESET;
            mask_r <= MASK_RESET;
            ctrl_r <= CTRL_RESET;
            rxd_r <= 32'h0000_0000;
            txd_r <= 32'h0000_0000;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            irq_r <= 1'b0;
            hold_r <= 1'b0;
            crc_seen_r <= 1'b0;
            prog_seen_r <= 1'b0;
            dp_r <= DP_IDLE;
        end else begin
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            ctrl_r <= ctrl_nxt;
            rxd_r <= rxd_nxt;
            txd_r <= txd_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            irq_r <= irq_nxt;
            hold_r <= hold_nxt;
            crc_seen_r <= crc_seen_nxt;
            prog_seen_r <= prog_seen_nxt;
            dp_r <= dp_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign irq = irq_r;
    assign tx_word = txd_r;
    assign data_path_reset = ctrl_r[C_DATA_RESET];
    assign data_path_hold = hold_r;
endmodule : sdces_top

// ==== common/sdces_pkg.sv ====
// Package: register map and field layout of the card event status block
package sdces_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_MASK = 8'h08;
    localparam logic [7:0] ADDR_RXDATA = 8'h0C;
    localparam logic [7:0] ADDR_TXDATA = 8'h10;
    // Status bit positions
    localparam int B_DATA_COMPLETE = 0;
    localparam int B_BUSY_DONE = 1;
    localparam int B_CMD_RESP_DONE = 2;
    localparam int B_READ_TIMEOUT = 3;
    localparam int B_RESP_TIMEOUT = 4;
    localparam int B_WRITE_CRC = 5;
    localparam int B_READ_CRC = 6;
    localparam int B_RESP_CRC = 7;
    localparam int B_TX_READY = 9;
    localparam int B_RX_READY = 10;
    localparam int B_DAT3_EDGE = 11;
    localparam int B_XFER_DONE = 12;
    localparam int STATUS_W = 13;
    // Bits cleared by a status read
    localparam logic [12:0] READ_CLEAR_MASK = 13'h18FF;
    localparam logic [12:0] STATUS_RESET = 13'h0200;
    // Control fields
    localparam int C_DATA_RESET = 0;
    localparam int C_EDGE_LO = 6;
    localparam int C_EDGE_HI = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [12:0] MASK_RESET = 13'h0000;
    // DAT3 edge select codes
    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    typedef enum logic [1:0] {
        DP_IDLE,
        DP_XFER,
        DP_WAIT_BUSY
    } sdces_dp_e;
endpackage : sdces_pkg

// ==== hw/sdces_dat3_edge.sv ====
// DAT3 pin synchroniser and selectable edge detector
`timescale 1ns/1ps
module sdces_dat3_edge
    import sdces_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic hold_reset,
    input wire logic [1:0] edge_sel,
    // Pin and event
    input wire logic dat3_in,
    output logic edge_pulse
);
    logic meta_r;
    logic meta_nxt;
    logic sync_r;
    logic sync_nxt;
    logic last_r;
    logic last_nxt;
    logic pulse_r;
    logic pulse_nxt;
    logic rise;
    logic fall;

    always_comb begin
        meta_nxt = dat3_in;
        sync_nxt = meta_r;
        last_nxt = sync_r;
        rise = sync_r & ~last_r;
        fall = ~sync_r & last_r;
        case (edge_sel)
            EDGE_RISE: pulse_nxt = rise;
            EDGE_FALL: pulse_nxt = fall;
            EDGE_BOTH: pulse_nxt = rise | fall;
            default: pulse_nxt = 1'b0;
        endcase
        // Held quiet while the data side is in reset
        if (hold_reset) begin
            pulse_nxt = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Idle high like the pin, so leaving reset shows no false edge
            meta_r <= 1'b1;
            sync_r <= 1'b1;
            last_r <= 1'b1;
            pulse_r <= 1'b0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            last_r <= last_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    assign edge_pulse = pulse_r;
endmodule : sdces_dat3_edge

// ==== tb/sdces_card_model.sv ====
// Card-side model: event strobes, receive words and DAT3 pin
`timescale 1ns/1ps
module sdces_card_model (
    // From the bench
    input wire logic pclk,
    input wire logic [14:0] ev_req,
    input wire logic [31:0] rx_in,
    input wire logic dat3_want,
    // Toward the controller
    output logic [14:0] ev,
    output logic [31:0] rx_word,
    output logic dat3_in
);
    logic lclk;
    initial begin
        lclk = 1'b0;
        #37;
        forever #80 lclk = ~lclk;
    end
    // Card answers even while a block is moving
    always @(posedge pclk) begin
        ev <= ev_req;
        rx_word <= ev_req[12] ? rx_in : ~rx_in;
    end
    // Pin moves on the card's own clock, unrelated to pclk
    always @(posedge lclk) begin
        dat3_in <= dat3_want;
    end
endmodule : sdces_card_model

// ==== tb/sdces_top_chk.sv ====
// Port assertions for the card event status block
`timescale 1ns/1ps
module sdces_top_chk
    import sdces_pkg::*;
(
    // Watched ports
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cmd_issue,
    input wire logic cmd_busy_expected,
    input wire logic busy_released,
    input wire logic busy_not_seen,
    input wire logic dma_tx_write,
    input wire logic [31:0] dma_tx_word,
    input wire logic [31:0] tx_word,
    input wire logic data_path_reset,
    input wire logic data_path_hold
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr_ctrl = psel && penable && pready && pwrite && paddr == ADDR_CTRL;
    wire wr_tx = psel && penable && pready && pwrite && paddr == ADDR_TXDATA;
    wire ends = busy_released || busy_not_seen;
    apb_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    apb_once_a: assert property (pready |=> !pready)
        else $error("pready too long");
    slv_err_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    tx_load_a: assert property (dma_tx_write && !wr_tx |=>
        tx_word == $past(dma_tx_word)) else $error("tx word not loaded");
    ctrl_reset_a: assert property (wr_ctrl |=>
        data_path_reset == $past(pwdata[0])) else $error("data reset wrong");
    hold_keep_a: assert property (data_path_hold && !ends && !wr_ctrl
        && !data_path_reset |=> data_path_hold) else $error("hold dropped");
    hold_end_a: assert property (data_path_hold && ends && !cmd_issue
        |=> !data_path_hold) else $error("hold kept");
    hold_none_a: assert property (!data_path_hold && cmd_issue
        && !cmd_busy_expected |=> !data_path_hold) else $error("hold set");
    reset_hold_a: assert property (data_path_reset |=> !data_path_hold)
        else $error("hold in reset");
    cover property (data_path_hold);
    cover property (pslverr);
    cover property (data_path_reset);
endmodule : sdces_top_chk
bind sdces_top sdces_top_chk sdces_top_chk_i (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .cmd_issue,
    .cmd_busy_expected, .busy_released, .busy_not_seen, .dma_tx_write,
    .dma_tx_word, .tx_word, .data_path_reset, .data_path_hold);

// ==== tb/testbench.sv ====
// Self-checking bench for the card event status block
`timescale 1ns/1ps
module testbench
    import sdces_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, w, rx_in, rx_word, tx_word, dma_tx_word;
    logic cmd_data_clear, cmd_busy_expected, dma_rx_read, dma_tx_write;
    logic dat3_want, dat3_in, data_path_reset, data_path_hold, sirq, shold;
    logic [14:0] ev_req, ev;
    int num_errors, compares, st, seed;
    int bitof[14] = '{2, 7, 4, 0, 12, 6, 5, 3, 0, 0, 1, 1, 10, 0};
    int single[8] = '{0, 1, 2, 5, 6, 7, 10, 11};
    sdces_card_model sdces_card_model_i (.pclk, .ev_req, .rx_in, .dat3_want,
        .ev, .rx_word, .dat3_in);
    sdces_top sdces_top_i (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .cmd_issue(ev[14]),
        .cmd_data_clear, .cmd_busy_expected, .resp_done(ev[0]),
        .resp_crc_err(ev[1]), .resp_timeout_evt(ev[2]), .xfer_start(ev[3]),
        .last_byte_done(ev[4]), .read_crc_err(ev[5]),
        .write_crc_err(ev[6]), .read_timeout_evt(ev[7]),
        .crc_check_done(ev[8]), .card_prog_done(ev[9]),
        .busy_released(ev[10]), .busy_not_seen(ev[11]),
        .rx_word_valid(ev[12]), .rx_word, .dma_rx_read, .dma_tx_write,
        .dma_tx_word, .tx_word_taken(ev[13]), .tx_word, .dat3_in,
        .data_path_reset, .data_path_hold, .irq);
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic end_sim();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (k >= 16) begin
            num_errors++;
            end_sim();
        end
    endtask : apb
    // Read status, then drop what the read clears from the model
    task automatic rds();
        apb(1'b0, ADDR_STATUS, '0);
        chk("status", rd, st);
        st = st & 32'h0600;
    endtask : rds
    // Irq is judged in its one pulse cycle, hold once it has settled
    task automatic fire(input logic [14:0] m);
        ev_req <= m;
        @(posedge pclk);
        ev_req <= '0;
        @(posedge pclk);
        #1;
        sirq = irq;
        @(posedge pclk);
        #1;
        shold = data_path_hold;
        @(posedge pclk);
    endtask : fire
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, dma_rx_read, dma_tx_write} = '0;
        {cmd_data_clear, cmd_busy_expected, paddr, pwdata, ev_req} = '0;
        {rx_in, dma_tx_word} = '0;
        dat3_want = 1'b1;
        {num_errors, compares} = '0;
        st = 32'h200;
        seed = 32'hd00a_2219;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rds();
        apb(1'b0, ADDR_MASK, '0);
        chk("mask", rd, 0);
        apb(1'b0, 8'h40, '0);
        chk("slverr", er, 1);
        apb(1'b1, ADDR_MASK, 32'h1fff);
        foreach (single[i]) begin
            fire(15'h1 << single[i]);
            st = st | (1 << bitof[single[i]]);
            chk("irq", sirq, 1);
            rds();
            rds();
        end
        apb(1'b1, ADDR_MASK, '0);
        fire(15'h2);
        st = st | 32'h80;
        chk("irq", sirq, 0);
        rds();
        fire(15'h10);
        fire(15'h100);
        st = st | 32'h1000;
        rds();
        fire(15'h200);
        st = st | 32'h1;
        rds();
        fire(15'h10);
        fire(15'h300);
        st = st | 32'h1001;
        rds();
        fire(15'h2000);
        st = st & ~32'h200;
        for (int k = 0; k < 3; k++) begin
            w = $random(seed);
            rx_in <= w;
            fire(15'h1000);
            st = st | 32'h400;
            rds();
            rds();
            if (k == 0) begin
                apb(1'b0, ADDR_RXDATA, '0);
                chk("rxdata", rd, w);
            end else if (k == 1) begin
                dma_rx_read <= 1'b1;
                @(posedge pclk);
                dma_rx_read <= 1'b0;
            end else begin
                cmd_data_clear <= 1'b1;
                fire(15'h4000);
                cmd_data_clear <= 1'b0;
                st = st | 32'h200;
            end
            st = st & ~32'h400;
            rds();
        end
        for (int k = 0; k < 2; k++) begin
            w = $random(seed);
            fire(15'h2000);
            st = st & ~32'h200;
            rds();
            if (k == 0) begin
                apb(1'b1, ADDR_TXDATA, w);
            end else begin
                dma_tx_word <= w;
                dma_tx_write <= 1'b1;
                @(posedge pclk);
                dma_tx_write <= 1'b0;
            end
            @(posedge pclk);
            chk("txword", tx_word, w);
            st = st | 32'h200;
            rds();
        end
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, ADDR_CTRL, c << 6);
            dat3_want <= 1'b0;
            repeat (30) @(posedge pclk);
            st = st | (c[1] << 11);
            rds();
            dat3_want <= 1'b1;
            repeat (30) @(posedge pclk);
            st = st | (c[0] << 11);
            rds();
        end
        fire(15'h1000);
        fire(15'h2000);
        st = (st | 32'h400) & ~32'h200;
        rds();
        apb(1'b1, ADDR_CTRL, 32'h1);
        @(posedge pclk);
        chk("dreset", data_path_reset, 1);
        st = st & ~32'h400 | 32'h200;
        rds();
        apb(1'b1, ADDR_CTRL, '0);
        fire(15'h8);
        fire(15'h4000);
        chk("hold", shold, 0);
        cmd_busy_expected <= 1'b1;
        fire(15'h4000);
        cmd_busy_expected <= 1'b0;
        chk("hold", shold, 1);
        fire(15'h400);
        chk("hold", shold, 0);
        st = st | 32'h2;
        rds();
        end_sim();
    end
endmodule : testbench
